/* File: src/msa_pkg.sv */
// Package for the mid-speed converter result and control registers.
// Assumes an 8-bit on-chip peripheral bus with byte addresses.
package msa_pkg;

	localparam logic [31:0] RES_A_HI_ADDR  = 32'hFFFF8420;
	localparam logic [31:0] RES_A_LO_ADDR  = 32'hFFFF8421;
	localparam logic [31:0] RES_B_HI_ADDR  = 32'hFFFF8422;
	localparam logic [31:0] RES_B_LO_ADDR  = 32'hFFFF8423;
	localparam logic [31:0] RES_C_HI_ADDR  = 32'hFFFF8424;
	localparam logic [31:0] RES_C_LO_ADDR  = 32'hFFFF8425;
	localparam logic [31:0] RES_D_HI_ADDR  = 32'hFFFF8426;
	localparam logic [31:0] RES_D_LO_ADDR  = 32'hFFFF8427;
	localparam logic [31:0] CTRL_STAT_ADDR = 32'hFFFF8428;
	localparam logic [31:0] TRIG_CTRL_ADDR = 32'hFFFF8429;

	localparam logic [7:0]  CTRL_STAT_RST  = 8'h00;
	localparam logic [7:0]  TRIG_CTRL_RST  = 8'h7F;
	localparam logic [15:0] RESULT_RST     = 16'h0000;

	localparam int BIT_END_FLAG = 7;
	localparam int BIT_IRQ_EN   = 6;
	localparam int BIT_START    = 5;
	localparam int BIT_SCAN     = 4;
	localparam int BIT_CLK_SEL  = 3;
	localparam int BIT_TRIG_EN  = 7;

	// Minimum conversion time per channel, at 100 MHz
	localparam int CONV_TIME_NS  = 6700;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		MSA_IDLE = 2'b00,
		MSA_CONV = 2'b01,
		MSA_WAIT = 2'b10
	} msa_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [31:0] addr;
		logic [7:0] wdata;
	} msa_bus_req_t;

endpackage : msa_pkg

/* File: src/msa_adc_regs.sv */
// Result and control registers of an eight-channel 10-bit converter.
// Assumes an 8-bit peripheral bus (one access per strobe) and an external
// analog core that returns a 10-bit sample on request.
//
// Behaviour
// [R01] Results stored left-justified, 8 high, 2 low
// [R02] Low six bits of low byte read zero
// [R03] Channel position selects result register A-D
// [R04] Inputs 0-3 group zero, 4-7 group one
// [R05] High byte direct, low byte via holding register
// [R06] Result registers clear at reset
// [R07] End flag cleared only by writing zero
// [R08] Four result registers hold per-channel results
// [R09] Single mode one channel, scan one-to-four channels
// [R10] End interrupt raised when enabled
// [R11] Timer trigger may start conversion
// [R12] Conversion per channel no shorter than minimum
// [R13] High byte read loads low byte holder
// [R14] Select field: group bit, channel or range end
// [R15] Flag set after single or all scan channels
// [R16] Scan converts ascending from group's first channel
module msa_adc_regs
	import msa_pkg::*;
#(
	parameter int CONV_LEN = CONV_CYCLES
) (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_n_in,
	input  wire msa_bus_req_t bus_req_in,
	output logic [7:0]        bus_rdata_out,
	input  wire logic         timer_trig_in,
	input  wire logic [9:0]   sample_in,
	output logic [2:0]        conv_chan_out,
	output logic              conv_busy_out,
	output logic              conv_end_irq_out
);

	logic       rst_s1_q, rst_n_q;
	logic [7:0] ctrl_q;
	logic       trig_en_q;
	logic [9:0] result_q [4];
	logic [1:0] temp_q;
	logic [7:0] rdata_q;
	logic [1:0] chan_q;
	logic [12:0] cnt_q;
	msa_state_t state_q;
	logic       done_last;
	logic       conv_done;
	logic       start_req;
	logic       wr_ctrl, wr_trig;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	assign wr_ctrl   = bus_req_in.wr && bus_req_in.addr == CTRL_STAT_ADDR;
	assign wr_trig   = bus_req_in.wr && bus_req_in.addr == TRIG_CTRL_ADDR;
	assign conv_done = state_q == MSA_CONV && cnt_q == 13'(CONV_LEN - 1);
	assign done_last = conv_done && (!ctrl_q[BIT_SCAN] || chan_q == ctrl_q[1:0]);
	assign start_req = trig_en_q && timer_trig_in; // [R11]

	// Control/status register; end flag set wins over clear
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= CTRL_STAT_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q[6:0] <= bus_req_in.wdata[6:0];
				if (!bus_req_in.wdata[BIT_END_FLAG])
					ctrl_q[BIT_END_FLAG] <= 1'b0; // [R07]
			end
			if (start_req)
				ctrl_q[BIT_START] <= 1'b1; // [R11]
			if (done_last) begin
				ctrl_q[BIT_END_FLAG] <= 1'b1; // [R15]
				if (!ctrl_q[BIT_SCAN])
					ctrl_q[BIT_START] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			trig_en_q <= TRIG_CTRL_RST[BIT_TRIG_EN];
		end else if (wr_trig) begin
			trig_en_q <= bus_req_in.wdata[BIT_TRIG_EN];
		end
	end

	// Sequencer: one channel per CONV_LEN cycles, scan pauses on flag only when the interrupt is enabled
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= MSA_IDLE;
			cnt_q   <= '0;
			chan_q  <= '0;
		end else begin
			case (state_q)
				MSA_IDLE: begin
					cnt_q <= '0;
					if (ctrl_q[BIT_START]) begin
						state_q <= MSA_CONV;
						chan_q  <= ctrl_q[BIT_SCAN] ? 2'b00 : ctrl_q[1:0]; // [R09] [R14] [R16]
					end
				end
				MSA_CONV: begin
					if (!ctrl_q[BIT_START]) begin
						state_q <= MSA_IDLE;
					end else if (conv_done) begin // [R12]
						cnt_q <= '0;
						if (!ctrl_q[BIT_SCAN]) begin
							state_q <= MSA_IDLE;
						end else if (chan_q == ctrl_q[1:0]) begin
							chan_q  <= 2'b00; // [R16]
							state_q <= ctrl_q[BIT_IRQ_EN] ? MSA_WAIT : MSA_CONV;
						end else begin
							chan_q <= chan_q + 2'b01; // [R16]
						end
					end else begin
						cnt_q <= cnt_q + 13'h0001;
					end
				end
				MSA_WAIT: begin
					if (!ctrl_q[BIT_START])
						state_q <= MSA_IDLE;
					else if (!ctrl_q[BIT_END_FLAG])
						state_q <= MSA_CONV;
				end
				default: state_q <= MSA_IDLE;
			endcase
		end
	end

	// Result storage by channel position within group
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int i = 0; i < 4; i++)
				result_q[i] <= RESULT_RST[9:0]; // [R06]
		end else if (conv_done && ctrl_q[BIT_START]) begin
			result_q[chan_q] <= sample_in; // [R03] [R08]
		end
	end

	// Read path: high byte direct, low byte from holding register
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			temp_q  <= '0;
			rdata_q <= '0;
		end else begin
			rdata_q <= 8'h00;
			if (bus_req_in.rd) begin
				if (bus_req_in.addr >= RES_A_HI_ADDR && bus_req_in.addr <= RES_D_LO_ADDR) begin
					if (!bus_req_in.addr[0]) begin
						rdata_q <= result_q[bus_req_in.addr[2:1]][9:2]; // [R01] [R05]
						temp_q  <= result_q[bus_req_in.addr[2:1]][1:0]; // [R13]
					end else begin
						rdata_q <= {temp_q, 6'b000000}; // [R02] [R05] [R13]
					end
				end else if (bus_req_in.addr == CTRL_STAT_ADDR) begin
					rdata_q <= ctrl_q;
				end else if (bus_req_in.addr == TRIG_CTRL_ADDR) begin
					rdata_q <= {trig_en_q, TRIG_CTRL_RST[6:0]};
				end
			end
		end
	end

	assign bus_rdata_out    = rdata_q;
	assign conv_chan_out    = {ctrl_q[2], chan_q}; // [R04] [R14]
	assign conv_busy_out    = state_q == MSA_CONV;
	assign conv_end_irq_out = ctrl_q[BIT_END_FLAG] && ctrl_q[BIT_IRQ_EN]; // [R10]

	property p_flag_on_last;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		done_last |=> ctrl_q[BIT_END_FLAG];
	endproperty
	a_flag_on_last: assert property (p_flag_on_last) else $error("end flag not set"); // [R15]

	property p_store;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(conv_done && ctrl_q[BIT_START]) |=> result_q[$past(chan_q)] == $past(sample_in);
	endproperty
	a_store: assert property (p_store) else $error("result not stored"); // [R08]

	property p_low_zero;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(bus_req_in.rd && bus_req_in.addr[31:4] == RES_A_HI_ADDR[31:4] && bus_req_in.addr[3] == 1'b0
			&& bus_req_in.addr[0]) |=> rdata_q[5:0] == 6'b000000;
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("reserved bits nonzero"); // [R02]

	property p_min_time;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		conv_done |-> cnt_q >= 13'(CONV_CYCLES - 1);
	endproperty
	a_min_time: assert property (p_min_time) else $error("conversion too short"); // [R12]

	property p_irq;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(done_last && ctrl_q[BIT_IRQ_EN] && !wr_ctrl) |=> conv_end_irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not raised on end"); // [R10]

	property p_trig;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(trig_en_q && timer_trig_in && !done_last) |=> ctrl_q[BIT_START];
	endproperty
	a_trig: assert property (p_trig) else $error("trigger ignored"); // [R11]

	property p_no_set;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(!ctrl_q[BIT_END_FLAG] && !done_last) |=> !ctrl_q[BIT_END_FLAG];
	endproperty
	a_no_set: assert property (p_no_set) else $error("flag set by write"); // [R07]

	property p_scan_order;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(conv_done && ctrl_q[BIT_SCAN] && ctrl_q[BIT_START] && chan_q != ctrl_q[1:0])
			|=> chan_q == $past(chan_q) + 2'b01;
	endproperty
	a_scan_order: assert property (p_scan_order) else $error("scan order wrong"); // [R16]

	property p_single_stop;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(done_last && !ctrl_q[BIT_SCAN]) |=> !ctrl_q[BIT_START];
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("single start not cleared"); // [R09]

	property p_scan_first;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(state_q == MSA_IDLE && ctrl_q[BIT_START] && ctrl_q[BIT_SCAN]) |=> chan_q == 2'b00 && conv_busy_out;
	endproperty
	a_scan_first: assert property (p_scan_first) else $error("scan not from first channel"); // [R16]

	property p_scan_wrap;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(conv_done && ctrl_q[BIT_SCAN] && ctrl_q[BIT_START] && chan_q == ctrl_q[1:0]) |=> chan_q == 2'b00;
	endproperty
	a_scan_wrap: assert property (p_scan_wrap) else $error("scan range end ignored"); // [R14]

	property p_single_chan;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(state_q == MSA_IDLE && ctrl_q[BIT_START] && !ctrl_q[BIT_SCAN] && !wr_ctrl)
			|=> conv_chan_out == $past(ctrl_q[2:0]);
	endproperty
	a_single_chan: assert property (p_single_chan) else $error("single channel wrong"); // [R14]

	property p_pause;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(state_q == MSA_WAIT && ctrl_q[BIT_END_FLAG]) |=> !conv_busy_out;
	endproperty
	a_pause: assert property (p_pause) else $error("scan did not pause on flag"); // [R10]

	property p_high_read;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(bus_req_in.rd && bus_req_in.addr[31:3] == RES_A_HI_ADDR[31:3] && !bus_req_in.addr[0])
			|=> rdata_q == $past(result_q[bus_req_in.addr[2:1]][9:2]);
	endproperty
	a_high_read: assert property (p_high_read) else $error("high byte wrong"); // [R01] [R05]

	property p_holder;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(bus_req_in.rd && bus_req_in.addr[31:3] == RES_A_HI_ADDR[31:3] && !bus_req_in.addr[0])
			|=> temp_q == $past(result_q[bus_req_in.addr[2:1]][1:0]);
	endproperty
	a_holder: assert property (p_holder) else $error("holder not loaded"); // [R13]

	property p_low_read;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(bus_req_in.rd && bus_req_in.addr[31:3] == RES_A_HI_ADDR[31:3] && bus_req_in.addr[0])
			|=> rdata_q == {$past(temp_q), 6'b000000};
	endproperty
	a_low_read: assert property (p_low_read) else $error("low byte not from holder"); // [R05] [R13]

	property p_trig_off;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(!trig_en_q && !wr_ctrl && !ctrl_q[BIT_START]) |=> !ctrl_q[BIT_START];
	endproperty
	a_trig_off: assert property (p_trig_off) else $error("disabled trigger started"); // [R11]

	property p_flag_hold;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(ctrl_q[BIT_END_FLAG] && !(wr_ctrl && !bus_req_in.wdata[BIT_END_FLAG])) |=> ctrl_q[BIT_END_FLAG];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("end flag lost"); // [R07]

	property p_flag_clear;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		(wr_ctrl && !bus_req_in.wdata[BIT_END_FLAG] && !done_last) |=> !ctrl_q[BIT_END_FLAG];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("end flag not cleared"); // [R07]

	property p_rdata_idle;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		!bus_req_in.rd |=> rdata_q == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_result_hold;
		@(posedge clk_sys_in) disable iff (!rst_n_q)
		!(conv_done && ctrl_q[BIT_START]) |=> result_q[0] == $past(result_q[0]) && result_q[1] == $past(result_q[1])
			&& result_q[2] == $past(result_q[2]) && result_q[3] == $past(result_q[3]);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result changed without conversion"); // [R08]

endmodule : msa_adc_regs

/* File: verification/msa_analog_model.sv */
// Behavioural analog core that answers the converter with a sample.
// Assumes the design samples sample_in at the end of each conversion.
module msa_analog_model (
	input  wire logic [2:0] conv_chan_in,
	output logic      [9:0] sample_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Channel in the top and bottom bits so routing and holder slips show up
	assign sample_out = {conv_chan_in, 5'h0B, conv_chan_in[1:0]};
endmodule : msa_analog_model

/* File: verification/tb_mid_speed_adc_result_regs.sv */
// Self-checking bench for the converter result and control registers.
// Assumes the analog model drives sample_in from the channel being converted.
module tb_mid_speed_adc_result_regs
	import msa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic         clk_sys_in = 1'b0;
	logic         rst_n_in   = 1'b0;
	msa_bus_req_t req        = '0;
	logic         trig       = 1'b0;
	logic [7:0]   rdata;
	logic [9:0]   sample;
	logic [2:0]   chan;
	logic         busy;
	logic         irq;
	int           miscompares = 0;
	int           checked     = 0;
	int           busy_cycles = 0;

	initial forever #5 clk_sys_in = ~clk_sys_in;

	// Counts converting cycles where busy is settled
	always @(negedge clk_sys_in) begin
		if (busy)
			busy_cycles++;
	end

	msa_adc_regs dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bus_req_in(req),
		.bus_rdata_out(rdata), .timer_trig_in(trig), .sample_in(sample), .conv_chan_out(chan),
		.conv_busy_out(busy), .conv_end_irq_out(irq));
	msa_analog_model core (.conv_chan_in(chan), .sample_out(sample));

	task automatic final_report();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp8

	task automatic bus_wr(input logic [31:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk_sys_in);
		req = '0;
	endtask : bus_wr

	task automatic bus_rd(input logic [31:0] a, output logic [7:0] d);
		@(negedge clk_sys_in);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk_sys_in);
		req = '0;
		d = rdata;
	endtask : bus_rd

	task automatic rd_cmp(input logic [31:0] a, input logic [7:0] exp);
		logic [7:0] d;
		bus_rd(a, d);
		cmp8(d, exp);
	endtask : rd_cmp

	// Polls the status register, bounded
	task automatic wait_flag();
		logic [7:0] d;
		for (int i = 0; i < 2000; i++) begin
			bus_rd(CTRL_STAT_ADDR, d);
			if (d[BIT_END_FLAG] === 1'b1) return;
		end
		miscompares++;
		final_report();
	endtask : wait_flag

	// High byte first, then the held low byte
	task automatic chk_res(input int idx, input logic [2:0] c);
		logic [15:0] r;
		r = {c, 5'h0B, c[1:0], 6'h00};
		rd_cmp(RES_A_HI_ADDR + 32'(2 * idx), r[15:8]);
		rd_cmp(RES_A_HI_ADDR + 32'(2 * idx + 1), r[7:0]);
	endtask : chk_res

	task automatic t_reset();
		for (int i = 0; i < 8; i++) rd_cmp(RES_A_HI_ADDR + 32'(i), 8'h00);
		rd_cmp(CTRL_STAT_ADDR, 8'h00);
		rd_cmp(TRIG_CTRL_ADDR, 8'h7F);
		rd_cmp(32'hFFFF842A, 8'h00);
	endtask : t_reset

	task automatic t_single();
		int b0;
		b0 = busy_cycles;
		bus_wr(CTRL_STAT_ADDR, 8'h25);
		wait_flag();
		cmp8({7'h00, (busy_cycles - b0) >= CONV_CYCLES}, 8'h01);
		cmp8({7'h00, irq}, 8'h00);
		rd_cmp(CTRL_STAT_ADDR, 8'h85);
		chk_res(1, 3'd5);
		bus_wr(RES_B_HI_ADDR, 8'h00);
		chk_res(1, 3'd5);
		bus_wr(CTRL_STAT_ADDR, 8'h85);
		rd_cmp(CTRL_STAT_ADDR, 8'h85);
		bus_wr(CTRL_STAT_ADDR, 8'h05);
		rd_cmp(CTRL_STAT_ADDR, 8'h05);
		bus_wr(CTRL_STAT_ADDR, 8'h85);
		rd_cmp(CTRL_STAT_ADDR, 8'h05);
	endtask : t_single

	task automatic t_scan();
		bus_wr(CTRL_STAT_ADDR, 8'h73);
		wait_flag();
		cmp8({7'h00, irq}, 8'h01);
		bus_wr(CTRL_STAT_ADDR, 8'h00);
		cmp8({7'h00, irq}, 8'h00);
		for (int i = 0; i < 4; i++) chk_res(i, 3'(i));
		bus_wr(CTRL_STAT_ADDR, 8'h35);
		wait_flag();
		bus_wr(CTRL_STAT_ADDR, 8'h00);
		chk_res(0, 3'd4);
		chk_res(1, 3'd5);
		chk_res(2, 3'd2);
		chk_res(3, 3'd3);
		rd_cmp(RES_D_HI_ADDR, 8'h6B);
		rd_cmp(RES_A_LO_ADDR, 8'hC0);
	endtask : t_scan

	task automatic t_trig();
		bus_wr(CTRL_STAT_ADDR, 8'h06);
		@(negedge clk_sys_in);
		trig = 1'b1;
		@(negedge clk_sys_in);
		trig = 1'b0;
		rd_cmp(CTRL_STAT_ADDR, 8'h06);
		bus_wr(TRIG_CTRL_ADDR, 8'h80);
		rd_cmp(TRIG_CTRL_ADDR, 8'hFF);
		@(negedge clk_sys_in);
		trig = 1'b1;
		@(negedge clk_sys_in);
		trig = 1'b0;
		wait_flag();
		chk_res(2, 3'd6);
	endtask : t_trig

	// Reset in mid-run must wipe results and the trigger enable
	task automatic t_midreset();
		@(negedge clk_sys_in);
		rst_n_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		t_reset();
	endtask : t_midreset

	initial begin
		repeat (20) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		t_reset();
		t_single();
		t_scan();
		t_trig();
		t_midreset();
		final_report();
	end
endmodule : tb_mid_speed_adc_result_regs
